// ==== hdl/drif_top.sv ====
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
// How it works
// (R1) Outside high-resolution mode a result interrupt needs some object farther than the far limit.
// (R2) Outside high-resolution mode a result interrupt needs some object nearer than the near limit.
// (R3) Outside high-resolution mode a result interrupt needs a detection in an enabled zone.
// (R4) The zone enable mask is 18 bits, bit n for zone n+1, bits 16-17 in the third mask byte.
// (R5) The far limit is 16 bits, low byte at the lower address, high byte next, both reset to 0.
// (R6) The near limit is 16 bits, low byte at the lower address, high byte next, both reset to 0.
// (R7) In high-resolution mode no qualification happens and bytes 0x28 to 0x2f are ignored.
// (R8) The persistence value counts the consecutive in-range measurements needed before the one that raises an interrupt.
// (R9) Persistence 0 fires on every in-range measurement, persistence 1 needs two in a row.
// (R10) The three conditions are ANDed per zone and the zones ORed, once per completed result, before the interrupt is raised.
module drif_top (
  input  wire logic                                       mclk,
  input  wire logic                                       reset,
  input  wire logic [drif_pkg::ADDR_W-1:0]                reg_addr,
  input  wire logic [drif_pkg::DATA_W-1:0]                reg_wdata,
  input  wire logic                                       reg_wr,
  input  wire logic                                       reg_rd,
  output logic      [drif_pkg::DATA_W-1:0]                reg_rdata,
  input  wire logic                                       result_valid,
  input  wire logic [drif_pkg::ZONES-1:0]                 zone_detect,
  input  wire logic [drif_pkg::ZONES*drif_pkg::DIST_W-1:0] zone_distance,
  output logic                                            irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [drif_pkg::DIST_W-1:0] far_limit;
    logic [drif_pkg::DIST_W-1:0] near_limit;
    logic [drif_pkg::ZONES-1:0]  zone_mask;
    logic [drif_pkg::DATA_W-1:0] persist;
    logic                        hires;
    logic [drif_pkg::ST_W-1:0]   status;
    logic [drif_pkg::ST_W-1:0]   imask;
    logic [drif_pkg::DATA_W-1:0] run;
    logic [drif_pkg::DATA_W-1:0] rdata;
  } drif_state_s;

  drif_state_s                state_r;
  drif_state_s                state_nxt;
  logic [drif_pkg::ZONES-1:0] z_far;
  logic [drif_pkg::ZONES-1:0] z_near;
  logic [drif_pkg::ZONES-1:0] z_armed;
  logic [drif_pkg::ZONES-1:0] z_hit;
  logic                       any_far;
  logic                       any_near;
  logic                       any_armed;
  logic                       any_hit;
  logic                       cfg_sel;
  logic                       cfg_wr;
  logic                       fire;
  logic                       drop;
  logic                       persist_wr;

  // ****************************************************************
  // zone comparators
  // ****************************************************************
  // one comparator per zone, mask bit n gates zone n+1
  genvar gi;
  generate
    for (gi = 0; gi < drif_pkg::ZONES; gi++) begin : g_zone
      drif_zone_cmp u_cmp (
        .enable      (state_r.zone_mask[gi]),                        // see (R4)
        .detect      (zone_detect[gi]),
        .distance    (zone_distance[gi*drif_pkg::DIST_W +: drif_pkg::DIST_W]),
        .far_limit   (state_r.far_limit),
        .near_limit  (state_r.near_limit),
        .beyond_far  (z_far[gi]),
        .within_near (z_near[gi]),
        .armed       (z_armed[gi]),
        .hit         (z_hit[gi])
      );
    end
  endgenerate

  // summary of the current result
  assign any_far   = |z_far;
  assign any_near  = |z_near;
  assign any_armed = |z_armed;
  assign any_hit   = |z_hit;                                         // see (R10)

  // ****************************************************************
  // qualification and persistence
  // ****************************************************************
  // configuration writes are blocked in high-resolution mode
  assign cfg_sel = (reg_addr >= drif_pkg::ADDR_FAR_LO) && (reg_addr <= drif_pkg::ADDR_CFG_LAST);
  assign cfg_wr  = reg_wr && cfg_sel && !state_r.hires;              // see (R7)

  // a new persistence setting starts a fresh run, so the count never overshoots it
  assign persist_wr = cfg_wr && (reg_addr == drif_pkg::ADDR_PERSIST); // see (R8)

  // decide per completed result whether it raises the interrupt
  always_comb begin
    fire = 1'b0;
    drop = 1'b0;
    if (result_valid) begin
      if (state_r.hires) begin
        fire = 1'b1;                                                 // see (R7)
      end else if (any_hit && (state_r.run >= state_r.persist)) begin
        fire = 1'b1;                                                 // see (R1) (R2) (R3) (R8) (R9)
      end else if (!any_hit) begin
        drop = 1'b1;
      end
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_nxt       = state_r;
    state_nxt.rdata = drif_pkg::RST_BYTE;
    // register read, data stands one cycle later
    if (reg_rd) begin
      case (reg_addr)
        drif_pkg::ADDR_FAR_LO:     state_nxt.rdata = state_r.far_limit[7:0];
        drif_pkg::ADDR_FAR_HI:     state_nxt.rdata = state_r.far_limit[15:8];
        drif_pkg::ADDR_NEAR_LO:    state_nxt.rdata = state_r.near_limit[7:0];
        drif_pkg::ADDR_NEAR_HI:    state_nxt.rdata = state_r.near_limit[15:8];
        drif_pkg::ADDR_ZONE_B0:    state_nxt.rdata = state_r.zone_mask[7:0];
        drif_pkg::ADDR_ZONE_B1:    state_nxt.rdata = state_r.zone_mask[15:8];
        drif_pkg::ADDR_ZONE_B2:    state_nxt.rdata = {6'h00, state_r.zone_mask[17:16]};
        drif_pkg::ADDR_PERSIST:    state_nxt.rdata = state_r.persist;
        drif_pkg::ADDR_IRQ_STATUS: state_nxt.rdata = {6'h00, state_r.status};
        drif_pkg::ADDR_IRQ_MASK:   state_nxt.rdata = {6'h00, state_r.imask};
        drif_pkg::ADDR_CONTROL:    state_nxt.rdata = {7'h00, state_r.hires};
        drif_pkg::ADDR_RUN_COUNT:  state_nxt.rdata = state_r.run;
        default:                   state_nxt.rdata = drif_pkg::RST_BYTE;
      endcase
    end
    // configuration byte writes
    if (cfg_wr) begin
      case (reg_addr)
        drif_pkg::ADDR_FAR_LO:  state_nxt.far_limit[7:0]   = reg_wdata; // see (R5)
        drif_pkg::ADDR_FAR_HI:  state_nxt.far_limit[15:8]  = reg_wdata; // see (R5)
        drif_pkg::ADDR_NEAR_LO: state_nxt.near_limit[7:0]  = reg_wdata; // see (R6)
        drif_pkg::ADDR_NEAR_HI: state_nxt.near_limit[15:8] = reg_wdata; // see (R6)
        drif_pkg::ADDR_ZONE_B0: state_nxt.zone_mask[7:0]   = reg_wdata; // see (R4)
        drif_pkg::ADDR_ZONE_B1: state_nxt.zone_mask[15:8]  = reg_wdata; // see (R4)
        drif_pkg::ADDR_ZONE_B2: state_nxt.zone_mask[17:16] = reg_wdata[1:0]; // see (R4)
        drif_pkg::ADDR_PERSIST: state_nxt.persist          = reg_wdata;
        default:                state_nxt.persist          = state_r.persist;
      endcase
    end
    // interrupt and control registers
    if (reg_wr) begin
      case (reg_addr)
        drif_pkg::ADDR_IRQ_STATUS: state_nxt.status = state_r.status & ~reg_wdata[1:0];
        drif_pkg::ADDR_IRQ_MASK:   state_nxt.imask  = reg_wdata[1:0];
        drif_pkg::ADDR_CONTROL:    state_nxt.hires  = reg_wdata[drif_pkg::CTRL_HIRES_BIT];
        default:                   state_nxt.imask  = state_r.imask;
      endcase
    end
    // consecutive in-range run counter
    if (result_valid) begin
      if (state_r.hires || fire || !any_hit) begin
        state_nxt.run = drif_pkg::RST_BYTE;                          // see (R8)
      end else begin
        state_nxt.run = 8'(state_r.run + drif_pkg::RUN_ONE);         // see (R8) (R9)
      end
    end
    // a persistence write wins over a result in the same cycle
    if (persist_wr) begin
      state_nxt.run = drif_pkg::RST_BYTE;                            // see (R8)
    end
    // events set after clear so a set in the clearing cycle wins
    if (fire) begin
      state_nxt.status[drif_pkg::ST_RESULT] = 1'b1;                  // see (R10)
    end
    if (drop) begin
      state_nxt.status[drif_pkg::ST_DROPPED] = 1'b1;
    end
  end

  // ****************************************************************
  // registers and outputs
  // ****************************************************************
  // single state register, all fields clear at reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= '0;                                                 // see (R5) (R6)
    end else begin
      state_r <= state_nxt;
    end
  end

  // level interrupt while any unmasked status bit is set
  assign irq       = |(state_r.status & state_r.imask);
  assign reg_rdata = state_r.rdata;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // a configuration write while normal mode is active
  sequence s_cfg_write(logic [drif_pkg::ADDR_W-1:0] a);
    reg_wr && (reg_addr == a) && !state_r.hires;
  endsequence

  // a configuration write attempted while high-resolution mode is active
  sequence s_hires_write;
    reg_wr && cfg_sel && state_r.hires;
  endsequence

  // two consecutive in-range results with persistence one
  sequence s_two_hits;
    result_valid && any_hit && !state_r.hires && (state_r.persist == 8'h01)
      && (state_r.run == 8'h01);
  endsequence

  a_far_low_store: assert property (s_cfg_write(drif_pkg::ADDR_FAR_LO) |=> // see (R5)
      state_r.far_limit[7:0] == $past(reg_wdata))
    else $error("far limit low byte not stored");

  a_near_high_store: assert property (s_cfg_write(drif_pkg::ADDR_NEAR_HI) |=> // see (R6)
      state_r.near_limit[15:8] == $past(reg_wdata))
    else $error("near limit high byte not stored");

  a_zone_top_store: assert property (s_cfg_write(drif_pkg::ADDR_ZONE_B2) |=> // see (R4)
      state_r.zone_mask[17:16] == $past(reg_wdata[1:0]))
    else $error("zone mask bits 16-17 not stored");

  a_hires_ignores: assert property (s_hires_write |=> // see (R7)
      $stable(state_r.far_limit) && $stable(state_r.near_limit) && $stable(state_r.zone_mask)
      && $stable(state_r.persist))
    else $error("configuration changed in high-resolution mode");

  a_fire_far: assert property (fire && !state_r.hires |-> any_far) // see (R1)
    else $error("interrupt without object beyond far limit");

  a_fire_near: assert property (fire && !state_r.hires |-> any_near) // see (R2)
    else $error("interrupt without object within near limit");

  a_fire_zone: assert property (fire && !state_r.hires |-> any_armed) // see (R3)
    else $error("interrupt without enabled zone detection");

  a_persist_zero: assert property (result_valid && any_hit && !state_r.hires // see (R9)
      && (state_r.persist == 8'h00) |=> state_r.status[drif_pkg::ST_RESULT])
    else $error("persistence zero did not fire");

  a_persist_one: assert property (s_two_hits |=> // see (R9)
      state_r.status[drif_pkg::ST_RESULT] && (state_r.run == 8'h00))
    else $error("second consecutive hit did not fire");

  a_run_reach: assert property (fire && !state_r.hires |-> // see (R8)
      state_r.run == state_r.persist)
    else $error("interrupt before persistence reached");

  a_only_on_result: assert property (!result_valid |=> // see (R10)
      !$rose(state_r.status[drif_pkg::ST_RESULT]))
    else $error("result status set without a completed result");

  a_set_wins: assert property (fire && reg_wr // see (R10)
      && (reg_addr == drif_pkg::ADDR_IRQ_STATUS) |=> state_r.status[drif_pkg::ST_RESULT])
    else $error("event lost against clear");

  // ****************************************************************
  // result path checks
  // ****************************************************************
  // a completed result with an in-range enabled zone in normal mode
  sequence s_in_range;
    result_valid && any_hit && !state_r.hires;
  endsequence

  // a completed result with no qualifying zone
  sequence s_miss;
    result_valid && !any_hit;
  endsequence

  // a completed result while high-resolution mode is active
  sequence s_hires_result;
    result_valid && state_r.hires;
  endsequence

  a_run_step: assert property (s_in_range ##0 !persist_wr // see (R8)
      ##0 (state_r.run < state_r.persist) |=> state_r.run == $past(state_r.run) + 8'h01)
    else $error("run counter did not advance on an in-range result");

  a_miss_restart: assert property (s_miss |=> state_r.run == drif_pkg::RST_BYTE) // see (R8)
    else $error("run counter kept after a result with no hit");

  a_miss_dropped: assert property (s_miss ##0 !state_r.hires // see (R10)
      |=> state_r.status[drif_pkg::ST_DROPPED])
    else $error("result without a hit not flagged as dropped");

  a_hires_fires: assert property (s_hires_result |=> // see (R7)
      state_r.status[drif_pkg::ST_RESULT] && (state_r.run == drif_pkg::RST_BYTE))
    else $error("high-resolution result not reported unqualified");

  a_persist_restart: assert property (persist_wr |=> // see (R8)
      (state_r.persist == $past(reg_wdata)) && (state_r.run == drif_pkg::RST_BYTE))
    else $error("persistence write did not restart the run");

  // ****************************************************************
  // register port checks
  // ****************************************************************
  // a read strobe at a given address
  sequence s_reg_read(logic [drif_pkg::ADDR_W-1:0] a);
    reg_rd && (reg_addr == a);
  endsequence

  a_far_high_store: assert property (s_cfg_write(drif_pkg::ADDR_FAR_HI) |=> // see (R5)
      state_r.far_limit[15:8] == $past(reg_wdata))
    else $error("far limit high byte not stored");

  a_near_low_store: assert property (s_cfg_write(drif_pkg::ADDR_NEAR_LO) |=> // see (R6)
      state_r.near_limit[7:0] == $past(reg_wdata))
    else $error("near limit low byte not stored");

  a_zone_low_store: assert property (s_cfg_write(drif_pkg::ADDR_ZONE_B0) |=> // see (R4)
      state_r.zone_mask[7:0] == $past(reg_wdata))
    else $error("zone mask bits 0-7 not stored");

  a_zone_mid_store: assert property (s_cfg_write(drif_pkg::ADDR_ZONE_B1) |=> // see (R4)
      state_r.zone_mask[15:8] == $past(reg_wdata))
    else $error("zone mask bits 8-15 not stored");

  a_far_high_read: assert property (s_reg_read(drif_pkg::ADDR_FAR_HI) |=> // see (R5)
      reg_rdata == $past(state_r.far_limit[15:8]))
    else $error("far limit high byte read back wrong");

  a_near_low_read: assert property (s_reg_read(drif_pkg::ADDR_NEAR_LO) |=> // see (R6)
      reg_rdata == $past(state_r.near_limit[7:0]))
    else $error("near limit low byte read back wrong");

  a_zone_top_read: assert property (s_reg_read(drif_pkg::ADDR_ZONE_B2) |=> // see (R4)
      reg_rdata == {6'h00, $past(state_r.zone_mask[17:16])})
    else $error("zone mask top byte read back wrong");

  a_ctrl_store: assert property (reg_wr && (reg_addr == drif_pkg::ADDR_CONTROL) |=> // see (R7)
      state_r.hires == $past(reg_wdata[drif_pkg::CTRL_HIRES_BIT]))
    else $error("high-resolution control bit not stored");

  a_mask_store: assert property (reg_wr && (reg_addr == drif_pkg::ADDR_IRQ_MASK) |=> // see (R10)
      state_r.imask == $past(reg_wdata[1:0]))
    else $error("interrupt mask not stored");

  a_status_clear: assert property (reg_wr && !result_valid // see (R10)
      && (reg_addr == drif_pkg::ADDR_IRQ_STATUS)
      |=> (state_r.status & $past(reg_wdata[1:0])) == 2'h0)
    else $error("status bits not cleared by a one");

endmodule

// ==== hdl/drif_pkg.sv ====
// ****************************************************************
// constants of the distance result interrupt filter
// ****************************************************************
package drif_pkg;

  // widths and zone count
  localparam int ZONES   = 18;
  localparam int DIST_W  = 16;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 8;
  localparam int ST_W    = 2;
  localparam int MASK2_W = 2;

  // threshold and zone configuration bytes
  localparam logic [ADDR_W-1:0] ADDR_FAR_LO   = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_FAR_HI   = 8'h29;
  localparam logic [ADDR_W-1:0] ADDR_NEAR_LO  = 8'h2a;
  localparam logic [ADDR_W-1:0] ADDR_NEAR_HI  = 8'h2b;
  localparam logic [ADDR_W-1:0] ADDR_ZONE_B0  = 8'h2c;
  localparam logic [ADDR_W-1:0] ADDR_ZONE_B1  = 8'h2d;
  localparam logic [ADDR_W-1:0] ADDR_ZONE_B2  = 8'h2e;
  localparam logic [ADDR_W-1:0] ADDR_PERSIST  = 8'h2f;
  localparam logic [ADDR_W-1:0] ADDR_CFG_LAST = 8'h2f;

  // interrupt and control block
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 8'h41;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL    = 8'h42;
  localparam logic [ADDR_W-1:0] ADDR_RUN_COUNT  = 8'h43;

  // field positions
  localparam int ST_RESULT      = 0;
  localparam int ST_DROPPED     = 1;
  localparam int CTRL_HIRES_BIT = 0;

  // reset value and run counter step
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] RUN_ONE  = 8'h01;

endpackage

// ==== hdl/drif_zone_cmp.sv ====
`timescale 1ns/1ps
// ****************************************************************
// per-zone limit comparison
// ****************************************************************
module drif_zone_cmp (
  input  wire logic                        enable,
  input  wire logic                        detect,
  input  wire logic [drif_pkg::DIST_W-1:0] distance,
  input  wire logic [drif_pkg::DIST_W-1:0] far_limit,
  input  wire logic [drif_pkg::DIST_W-1:0] near_limit,
  output logic                             beyond_far,
  output logic                             within_near,
  output logic                             armed,
  output logic                             hit
);

  // only a detected object has a meaningful distance
  assign beyond_far  = detect && (distance > far_limit);
  assign within_near = detect && (distance < near_limit);
  assign armed       = enable && detect;
  assign hit         = armed && beyond_far && within_near;

endmodule

// ==== sim/drif_host_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// host side: drives the register port one strobe at a time
// ****************************************************************
module drif_host_model (
  input  wire logic                        mclk,
  output logic      [drif_pkg::ADDR_W-1:0] reg_addr,
  output logic      [drif_pkg::DATA_W-1:0] reg_wdata,
  output logic                             reg_wr,
  output logic                             reg_rd,
  input  wire logic [drif_pkg::DATA_W-1:0] reg_rdata
);
  // idle bus from time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // one write cycle; address and data turn to garbage once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  // one read cycle; data taken in the single cycle it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench of the result interrupt filter
// ****************************************************************
module testbench;
  logic         mclk;
  logic         reset;
  logic [7:0]   reg_addr;
  logic [7:0]   reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  logic [7:0]   reg_rdata;
  logic         result_valid;
  logic [17:0]  zone_detect;
  logic [287:0] zone_distance;
  logic         irq;
  logic [7:0]   got;
  logic [15:0]  far_e;
  logic [15:0]  near_e;
  logic [17:0]  zmask_e;
  logic [7:0]   pers_e;
  logic [7:0]   run_e;
  logic [1:0]   st_e;
  logic [1:0]   im_e;
  logic         hires_e;
  logic [31:0]  seed;
  logic [31:0]  r;
  logic [31:0]  r2;
  logic [287:0] dx;
  logic [15:0]  bv [4];
  int           err_total;
  int           checked;

  drif_top uut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result_valid(result_valid),
    .zone_detect(zone_detect), .zone_distance(zone_distance), .irq(irq));
  drif_host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected hit: one enabled, detecting zone strictly between the limits
  function automatic logic hit_f(input logic [17:0] d, input logic [287:0] x);
    logic h;
    h = 1'b0;
    for (int z = 0; z < 18; z++) begin
      if (zmask_e[z] && d[z] && x[16*z+:16] > far_e && x[16*z+:16] < near_e) begin
        h = 1'b1;
      end
    end
    return h;
  endfunction
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: byte got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_irq(input logic e);
    checked++;
    if (irq !== e) begin
      err_total++;
      $display("mismatch at %0t: irq got %b want %b", $time, irq, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, got);
    chk_byte(got, e);
  endtask
  task automatic cfg(input logic [15:0] f, input logic [15:0] n, input logic [17:0] m,
                     input logic [7:0] p);
    host.wr(drif_pkg::ADDR_FAR_LO, f[7:0]);
    host.wr(drif_pkg::ADDR_FAR_HI, f[15:8]);
    host.wr(drif_pkg::ADDR_NEAR_LO, n[7:0]);
    host.wr(drif_pkg::ADDR_NEAR_HI, n[15:8]);
    host.wr(drif_pkg::ADDR_ZONE_B0, m[7:0]);
    host.wr(drif_pkg::ADDR_ZONE_B1, m[15:8]);
    host.wr(drif_pkg::ADDR_ZONE_B2, {6'h00, m[17:16]});
    host.wr(drif_pkg::ADDR_PERSIST, p);
    far_e = f;
    near_e = n;
    zmask_e = m;
    pers_e = p;
    run_e = 8'h00; // a new persistence value restarts the run
  endtask
  // one result pulse, then status, run count and irq against the model
  task automatic res(input logic [17:0] d, input logic [287:0] x);
    logic h;
    h = hit_f(d, x);
    @(posedge mclk);
    zone_detect   <= d;
    zone_distance <= x;
    result_valid  <= 1'b1;
    @(posedge mclk);
    result_valid  <= 1'b0;
    zone_detect   <= ~d;
    zone_distance <= ~x;
    if (hires_e) begin
      st_e[0] = 1'b1;
      run_e = 8'h00;
    end else if (!h) begin
      st_e[1] = 1'b1;
      run_e = 8'h00;
    end else if (run_e >= pers_e) begin
      st_e[0] = 1'b1;
      run_e = 8'h00;
    end else begin
      run_e = run_e + 8'h01;
    end
    rdc(8'h40, {6'h00, st_e});
    rdc(8'h43, run_e);
    chk_irq(|(st_e & im_e));
    host.wr(8'h40, 8'h03);
    st_e = 2'b00;
    @(posedge mclk);
    #1;
    chk_irq(1'b0);
  endtask
  task automatic wrap_up();
    $display("counts: checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    err_total = 0;
    checked = 0;
    seed = 32'h0000ca5f;
    reset = 1'b1;
    result_valid = 1'b0;
    zone_detect = 18'h00000;
    zone_distance = 288'h0;
    far_e = 16'h0000;
    near_e = 16'h0000;
    zmask_e = 18'h00000;
    pers_e = 8'h00;
    run_e = 8'h00;
    st_e = 2'b00;
    im_e = 2'b00;
    hires_e = 1'b0;
    bv = '{16'h0100, 16'h0101, 16'h01ff, 16'h0200};
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    // reset values, unmapped holes included
    for (int a = 8'h28; a <= 8'h43; a++) rdc(a[7:0], 8'h00);
    rdc(8'h7f, 8'h00);
    $display("test reset_values done");
    // read back, reserved mask bits read zero
    for (int a = 8'h28; a <= 8'h2f; a++) begin
      r = xs();
      host.wr(a[7:0], r[7:0]);
      rdc(a[7:0], (a == 8'h2e) ? (r[7:0] & 8'h03) : r[7:0]);
    end
    host.wr(8'h41, 8'hff);
    rdc(8'h41, 8'h03);
    im_e = 2'b11;
    $display("test read_back done");
    // limit edges with high bytes in play, then the top two zones
    cfg(16'h0100, 16'h0200, 18'h00001, 8'h00);
    dx = 288'h0;
    for (int i = 0; i < 4; i++) begin
      dx[15:0] = bv[i];
      res(18'h00001, dx);
    end
    res(18'h00000, dx);
    cfg(16'h0100, 16'h0200, 18'h20000, 8'h00);
    dx[16*16+:16] = 16'h0150;
    dx[16*17+:16] = 16'h0150;
    res(18'h20000, dx);
    res(18'h10000, dx);
    $display("test limit_edges done");
    // persistence one: two in a row, a miss restarts the run
    cfg(16'h0010, 16'h0064, 18'h00001, 8'h01);
    dx = 288'h0;
    dx[15:0] = 16'h0032;
    // detect pattern hit, miss, hit, hit, miss, hit, hit
    for (int i = 0; i < 7; i++) begin
      r = 32'h0000006d >> i;
      res({17'h00000, r[0]}, dx);
    end
    cfg(16'h0010, 16'h0064, 18'h00001, 8'h02);
    repeat (4) res(18'h00001, dx);
    $display("test persistence done");
    // random results under random settings and irq masks
    for (int k = 0; k < 150; k++) begin
      if (k % 25 == 0) begin
        r = xs();
        r2 = xs();
        cfg({10'h000, r[5:0]}, {8'h00, 1'b1, r[14:8]}, r2[17:0], {6'h00, r[25:24]});
        host.wr(8'h41, {6'h00, r[27:26]});
        im_e = r[27:26];
      end
      for (int z = 0; z < 18; z++) begin
        r = xs();
        dx[16*z+:16] = {8'h00, r[7:0]};
      end
      r2 = xs();
      res(r2[17:0], dx);
    end
    $display("test random_results done");
    // high-resolution mode: writes ignored, every result fires
    host.wr(8'h42, 8'h01);
    rdc(8'h42, 8'h01);
    host.wr(8'h28, ~far_e[7:0]);
    rdc(8'h28, far_e[7:0]);
    hires_e = 1'b1;
    res(18'h00000, dx);
    host.wr(8'h42, 8'h00);
    hires_e = 1'b0;
    $display("test high_res done");
    wrap_up();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    $display("mismatch at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule
